/* srt_receiver.v */
// Sub-STM-1 section receiver: line decode, framing, checks and counters.
`timescale 1ns/1ps
`default_nettype none
`include "srt_defs.vh"
module srt_receiver #(
    parameter ONE_SEC_CYCLES = `SRT_CLK_HZ * `SRT_ONE_SEC_S,
    parameter EBC_WIDTH = 16
) (
    input wire clk_sys,
    input wire reset,
    input wire ce,
    input wire lineClk,
    input wire linePos,
    input wire lineNeg,
    input wire txBit,
    input wire txBitValid,
    output reg txPos,
    output reg txNeg,
    input wire [7:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata,
    output reg rxData,
    output reg rxBitStrobe,
    output reg rxFrameStart,
    output reg frameLossReport,
    output reg traceMismatchReport,
    output reg signalLossReport,
    output reg secondStrobe,
    output reg [EBC_WIDTH-1:0] nearErroredBlockCount,
    output reg nearDefectSecond
);
    localparam LOCAL_DIV = `SRT_LOCAL_DIV;
    localparam ST_HUNT = 2'd0;
    localparam ST_PRESYNC = 2'd1;
    localparam ST_INFRAME = 2'd2;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    reg [1:0] clkSync, posSync, negSync;
    reg clkLast;
    wire lineEdge = clkSync[1] & ~clkLast;

    // Two flip-flops on each pin; only the second stage is used.
    always @(posedge clk_sys) begin
        if (reset) begin
            clkSync <= 2'b00;
            posSync <= 2'b00;
            negSync <= 2'b00;
            clkLast <= 1'b0;
        end else if (ce) begin
            clkSync <= {clkSync[0], lineClk};
            posSync <= {posSync[0], linePos};
            negSync <= {negSync[0], lineNeg};
            clkLast <= clkSync[1];
        end
    end

    // ************************************************************
    // B3ZS decoder and signal loss
    // ************************************************************
    reg [1:0] decDelay;
    reg lastPolNeg;
    reg [7:0] zeroRun;
    reg signalLoss;
    reg decBit;
    reg decValid;
    wire pulseIn = posSync[1] ^ negSync[1];
    wire violation = pulseIn & (negSync[1] == lastPolNeg);

    // A pulse of the same polarity as the last one marks a substitution.
    always @(posedge clk_sys) begin
        if (reset) begin
            decDelay <= 2'b00;
            lastPolNeg <= 1'b1;
            zeroRun <= 8'h00;
            signalLoss <= 1'b1;
            decBit <= 1'b0;
            decValid <= 1'b0;
        end else if (ce) begin
            decValid <= lineEdge;
            if (lineEdge) begin
                if (violation) begin
                    decBit <= 1'b0;
                    decDelay <= 2'b00;
                end else begin
                    decBit <= decDelay[1];
                    decDelay <= {decDelay[0], pulseIn};
                end
                if (pulseIn) begin
                    lastPolNeg <= negSync[1];
                    zeroRun <= 8'h00;
                    signalLoss <= 1'b0;
                end else if (zeroRun == `SRT_LOS_ZEROS) begin
                    signalLoss <= 1'b1;
                end else begin
                    zeroRun <= zeroRun + 8'h01;
                end
            end
        end
    end

    // ************************************************************
    // Frame alignment
    // ************************************************************
    reg [15:0] shiftReg;
    reg [12:0] bitPos;
    reg [1:0] alignState;
    reg [2:0] badCount;
    wire [15:0] nextShift = {shiftReg[14:0], decBit};
    wire wordOk = (nextShift == `SRT_A1_A2);
    wire atCheck = (bitPos == `SRT_J0_FIRST - 13'd1);
    wire frameLoss = (alignState != ST_INFRAME);

    // Hunt bit by bit, then check once per frame at the presumed place.
    always @(posedge clk_sys) begin
        if (reset) begin
            shiftReg <= 16'h0000;
            bitPos <= 13'd0;
            alignState <= ST_HUNT;
            badCount <= 3'd0;
        end else if (ce && decValid) begin
            shiftReg <= nextShift;
            if (bitPos == `SRT_FRAME_BITS - 13'd1) begin
                bitPos <= 13'd0;
            end else begin
                bitPos <= bitPos + 13'd1;
            end
            case (alignState)
                ST_HUNT: begin
                    if (wordOk) begin
                        bitPos <= `SRT_J0_FIRST;
                        alignState <= ST_PRESYNC;
                    end
                end
                ST_PRESYNC: begin
                    if (atCheck) begin
                        if (wordOk) begin
                            alignState <= ST_INFRAME;
                            badCount <= 3'd0;
                        end else begin
                            alignState <= ST_HUNT;
                        end
                    end
                end
                default: begin
                    if (atCheck) begin
                        if (wordOk) begin
                            badCount <= 3'd0;
                        end else if (badCount == `SRT_BAD_TO_OOF - 3'd1) begin
                            alignState <= ST_HUNT;
                            badCount <= 3'd0;
                        end else begin
                            badCount <= badCount + 3'd1;
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Descrambler and BIP-8
    // ************************************************************
    reg [6:0] scr;
    reg [7:0] bipRun;
    reg [7:0] bipPrev;
    reg [7:0] b1Shift;
    reg blockError;
    reg bipGood;
    wire [2:0] lane = bitPos[2:0];
    wire inRow1 = (bitPos < `SRT_SCR_START);
    wire scrStart = (bitPos == `SRT_SCR_START);
    wire [6:0] scrNow = scrStart ? 7'h7F : scr;
    wire plainBit = inRow1 ? decBit : (decBit ^ scrNow[6]);
    reg [7:0] bipNext;

    // Even parity per lane over the bits as received, still scrambled.
    always @* begin
        bipNext = (bitPos == 13'd0) ? 8'h00 : bipRun;
        bipNext[7 - lane] = bipNext[7 - lane] ^ decBit;
    end

    // Frame-synchronous scrambler state, set to ones after row one.
    always @(posedge clk_sys) begin
        if (reset) begin
            scr <= 7'h7F;
            bipRun <= 8'h00;
            bipPrev <= 8'h00;
            b1Shift <= 8'h00;
            blockError <= 1'b0;
            bipGood <= 1'b0;
        end else if (ce) begin
            blockError <= 1'b0;
            if (decValid && alignState != ST_HUNT) begin
                bipRun <= bipNext;
                if (bitPos == `SRT_FRAME_BITS - 13'd1) begin
                    bipPrev <= bipNext;
                    bipGood <= ~frameLoss;
                end
            end
            if (decValid && alignState == ST_INFRAME) begin
                if (!inRow1) begin
                    scr <= {scrNow[5:0], scrNow[6] ^ scrNow[5]};
                end
                // E1, F1 and D1 to D3 are not examined at all.
                if (bitPos[12:3] == `SRT_B1_FIRST / 13'd8) begin
                    b1Shift <= {b1Shift[6:0], plainBit};
                end
                if (bitPos == `SRT_B1_FIRST + 13'd8) begin
                    blockError <= bipGood & (b1Shift != bipPrev);
                end
            end
        end
    end

    // ************************************************************
    // Trace identifier capture and mismatch
    // ************************************************************
    reg [7:0] expTrace [0:15];
    reg [3:0] traceIdx;
    reg [7:0] j0Shift;
    reg cycleMiss;
    reg [1:0] missRun, matchRun;
    reg traceMismatch;
    reg [1:0] ctrl;
    wire timEnable = ~ctrl[`SRT_CTRL_TIMDIS];
    wire mon = ctrl[`SRT_CTRL_MON];
    wire j0Done = decValid && (bitPos == `SRT_J0_FIRST + 13'd7);
    wire [7:0] j0Byte = {j0Shift[6:0], decBit};
    wire byteMiss = (j0Byte != expTrace[traceIdx]);
    wire traceDeclared = traceMismatch & timEnable & mon;

    // A full message must miss (or match) several times before it counts.
    always @(posedge clk_sys) begin
        if (reset) begin
            traceIdx <= 4'd0;
            j0Shift <= 8'h00;
            cycleMiss <= 1'b0;
            missRun <= 2'd0;
            matchRun <= 2'd0;
            traceMismatch <= 1'b0;
        end else if (ce && alignState == ST_INFRAME) begin
            if (decValid) begin
                j0Shift <= j0Byte;
            end
            if (j0Done) begin
                traceIdx <= traceIdx + 4'd1;
                cycleMiss <= (traceIdx == 4'd0) ? byteMiss
                                                : (cycleMiss | byteMiss);
                if (traceIdx == 4'd15) begin
                    if (cycleMiss | byteMiss) begin
                        matchRun <= 2'd0;
                        if (missRun == `SRT_TRACE_PERSIST - 2'd1) begin
                            traceMismatch <= 1'b1;
                        end else begin
                            missRun <= missRun + 2'd1;
                        end
                    end else begin
                        missRun <= 2'd0;
                        if (matchRun == `SRT_TRACE_PERSIST - 2'd1) begin
                            traceMismatch <= 1'b0;
                        end else begin
                            matchRun <= matchRun + 2'd1;
                        end
                    end
                end
            end
        end
    end

    // ************************************************************
    // Data output with all-ones substitution and local timing
    // ************************************************************
    reg [2:0] localDiv;
    wire aisOn = frameLoss | traceDeclared | signalLoss;
    wire localTick = (localDiv == LOCAL_DIV[2:0] - 3'd1);

    // Defects switch the output to ones on the next bit, well in time.
    always @(posedge clk_sys) begin
        if (reset) begin
            localDiv <= 3'd0;
            rxData <= 1'b1;
            rxBitStrobe <= 1'b0;
            rxFrameStart <= 1'b0;
        end else if (ce) begin
            localDiv <= localTick ? 3'd0 : localDiv + 3'd1;
            rxBitStrobe <= signalLoss ? localTick & ~lineEdge : decValid;
            rxData <= aisOn ? 1'b1 : plainBit;
            rxFrameStart <= decValid & ~frameLoss & (bitPos == 13'd0);
        end
    end

    // ************************************************************
    // One-second performance counters
    // ************************************************************
    reg [31:0] secCount;
    reg [EBC_WIDTH-1:0] ebcRun;
    reg dsRun;
    wire secEnd = (secCount == ONE_SEC_CYCLES - 1);
    wire frameLossDeclared = frameLoss & mon;

    // Counters restart at each local one-second boundary.
    always @(posedge clk_sys) begin
        if (reset) begin
            secCount <= 32'd0;
            ebcRun <= {EBC_WIDTH{1'b0}};
            dsRun <= 1'b0;
            secondStrobe <= 1'b0;
            nearErroredBlockCount <= {EBC_WIDTH{1'b0}};
            nearDefectSecond <= 1'b0;
            frameLossReport <= 1'b0;
            traceMismatchReport <= 1'b0;
            signalLossReport <= 1'b0;
        end else if (ce) begin
            frameLossReport <= frameLossDeclared;
            traceMismatchReport <= traceDeclared;
            signalLossReport <= signalLoss & mon;
            secondStrobe <= secEnd & mon;
            if (secEnd) begin
                secCount <= 32'd0;
                if (mon) begin
                    nearErroredBlockCount <= ebcRun
                        + {{(EBC_WIDTH-1){1'b0}}, blockError & ~&ebcRun};
                    nearDefectSecond <= dsRun | frameLossDeclared
                                        | traceDeclared;
                end
                ebcRun <= {EBC_WIDTH{1'b0}};
                dsRun <= 1'b0;
            end else begin
                secCount <= secCount + 32'd1;
                if (blockError && mon && ebcRun != {EBC_WIDTH{1'b1}}) begin
                    ebcRun <= ebcRun + 1'b1;
                end
                if (frameLossDeclared | traceDeclared) begin
                    dsRun <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    integer i;

    // Writes steer control and the expected trace; reads show state.
    always @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= `SRT_CTRL_RESET;
            regRdata <= 32'h00000000;
            for (i = 0; i < 16; i = i + 1) begin
                expTrace[i] <= 8'h00;
            end
        end else if (ce) begin
            if (regWr) begin
                if (regAddr == `SRT_REG_CTRL) begin
                    ctrl <= regWdata[1:0];
                end else if (regAddr[7:6] == 2'b01 && regAddr[1:0] == 2'b00) begin
                    expTrace[regAddr[5:2]] <= regWdata[7:0];
                end
            end
            if (regRd) begin
                if (regAddr == `SRT_REG_CTRL) begin
                    regRdata <= {30'h0, ctrl};
                end else if (regAddr == `SRT_REG_STATUS) begin
                    regRdata <= {28'h0, signalLoss, traceMismatch,
                                 frameLoss, alignState == ST_HUNT};
                end else if (regAddr == `SRT_REG_EBC) begin
                    regRdata <= {{(32 - EBC_WIDTH){1'b0}},
                                 nearErroredBlockCount};
                end else if (regAddr == `SRT_REG_DS) begin
                    regRdata <= {31'h0, nearDefectSecond};
                end else if (regAddr[7:6] == 2'b01 && regAddr[1:0] == 2'b00) begin
                    regRdata <= {24'h0, expTrace[regAddr[5:2]]};
                end else begin
                    regRdata <= 32'h00000000;
                end
            end else begin
                regRdata <= 32'h00000000;
            end
        end
    end

    // ************************************************************
    // B3ZS line encoder
    // ************************************************************
    reg [2:0] txBuf;
    reg [1:0] subPhase;
    reg subB0V;
    reg txLastNeg;
    reg oddSinceV;

    // Three zeros become 00V or B0V so that V pulses alternate.
    always @(posedge clk_sys) begin
        if (reset) begin
            txBuf <= 3'b000;
            subPhase <= 2'd0;
            subB0V <= 1'b0;
            txLastNeg <= 1'b1;
            oddSinceV <= 1'b0;
            txPos <= 1'b0;
            txNeg <= 1'b0;
        end else if (ce && txBitValid) begin
            txBuf <= {txBuf[1:0], txBit};
            txPos <= 1'b0;
            txNeg <= 1'b0;
            if (subPhase == 2'd2) begin
                txPos <= txLastNeg ? 1'b0 : 1'b1;
                txNeg <= txLastNeg;
                subPhase <= 2'd0;
                oddSinceV <= 1'b0;
            end else if (subPhase == 2'd1) begin
                subPhase <= 2'd2;
            end else if (txBuf == 3'b000) begin
                subPhase <= 2'd1;
                subB0V <= ~oddSinceV;
                if (!oddSinceV) begin
                    txPos <= txLastNeg;
                    txNeg <= ~txLastNeg;
                    txLastNeg <= ~txLastNeg;
                end
            end else if (txBuf[2]) begin
                txPos <= txLastNeg;
                txNeg <= ~txLastNeg;
                txLastNeg <= ~txLastNeg;
                oddSinceV <= ~oddSinceV;
            end
        end
    end
endmodule
`default_nettype wire

/* srt_defs.vh */
// Constants of the sub-STM-1 regenerator section receiver.
// What this block does
// - Descramble all but first overhead row.
// - Descrambler polynomial is x^7 + x^6 + 1.
// - Hunt A1/A2, keep checking presumed frame start.
// - Alignment word is 11110110 then 00101000.
// - Five errored alignment words enter out-of-frame.
// - Two good alignment words return in-frame.
// - Frame loss follows out-of-frame state.
// - Frame loss forces all-ones out quickly.
// - Report frame loss when monitored.
// - Compare accepted trace with expected, flag mismatch.
// - Trace mismatch forces all-ones, reported when monitored.
// - Management can disable trace mismatch detection.
// - Check B1 against even BIP-8 of frame.
// - Ignore E1, F1 and D1 to D3.
// - Count errored blocks per second.
// - Flag seconds with frame loss or mismatch.
// - Report count and defect second each second.
// - Unmonitored state suppresses declaration and reporting.
// - Transmit side encodes with B3ZS.
// - AMI with 00V or B0V zero substitution.
// - Violations alternate; decoder removes substitutions.
// - Recover timing, decode, hand data and clock on.
// - Signal loss forces all-ones with local clock.
`ifndef SRT_DEFS_VH
`define SRT_DEFS_VH
// ****************************************************************
// Frame geometry and alignment word
// ****************************************************************
`define SRT_FRAME_BITS 13'd6480
`define SRT_A1_A2 16'hF628
`define SRT_SCR_START 13'd24
`define SRT_J0_FIRST 13'd16
`define SRT_B1_FIRST 13'd720
`define SRT_TRACE_LEN 5'd16
`define SRT_BAD_TO_OOF 3'd5
`define SRT_GOOD_TO_IF 2'd2
`define SRT_TRACE_PERSIST 2'd3
// ****************************************************************
// Timing
// ****************************************************************
`define SRT_CLK_HZ 50000000
`define SRT_ONE_SEC_S 1
`define SRT_LINE_BIT_NS 160
`define SRT_LOCAL_DIV (`SRT_LINE_BIT_NS * (`SRT_CLK_HZ / 1000000) / 1000)
`define SRT_LOS_ZEROS 8'd175
// ****************************************************************
// Register offsets, fields and reset values
// ****************************************************************
`define SRT_REG_CTRL 8'h00
`define SRT_REG_STATUS 8'h04
`define SRT_REG_EBC 8'h08
`define SRT_REG_DS 8'h0C
`define SRT_REG_TRACE 8'h40
`define SRT_CTRL_MON 0
`define SRT_CTRL_TIMDIS 1
`define SRT_CTRL_RESET 2'h0
`endif

/* srt_receiver_monitor.sv */
// Port assertions for the section receiver.
`timescale 1ns/1ps
`default_nettype none
module srt_receiver_monitor (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic txBitValid,
    input wire logic txPos,
    input wire logic txNeg,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic rxData,
    input wire logic rxBitStrobe,
    input wire logic rxFrameStart,
    input wire logic frameLossReport,
    input wire logic traceMismatchReport,
    input wire logic signalLossReport,
    input wire logic secondStrobe
);
    // All checks use the system clock and rest during reset.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    AST_LOSS_ONES: assert property (signalLossReport [*3] |-> rxData)
        else $error("data not all ones during signal loss");
    AST_FRAME_ONES: assert property (frameLossReport [*3] |-> rxData)
        else $error("data not all ones during frame loss");
    AST_TRACE_ONES: assert property (traceMismatchReport [*3] |-> rxData)
        else $error("data not all ones during trace mismatch");
    AST_TX_BIPOLAR: assert property (!(txPos && txNeg))
        else $error("both line rails driven");
    AST_TX_HOLD: assert property (!$past(txBitValid) |-> $stable({txPos, txNeg}))
        else $error("line symbol changed without a new bit");
    AST_READ_IDLE: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside its cycle");
    AST_SECOND_PULSE: assert property (secondStrobe |=> !secondStrobe)
        else $error("second strobe longer than a cycle");
    AST_FRAME_START: assert property (rxFrameStart |-> !frameLossReport)
        else $error("frame start while frame lost");
    AST_FRAME_GAP: assert property (rxFrameStart |=> !rxFrameStart [*8])
        else $error("frame starts too close");
    AST_BIT_PULSE: assert property (rxBitStrobe |=> !rxBitStrobe)
        else $error("bit strobe longer than a cycle");
    // Main scenarios seen.
    cover property (rxFrameStart);
    cover property (secondStrobe);
    cover property ($fell(signalLossReport));
endmodule
`default_nettype wire

/* srt_line_model.sv */
// Remote line transmitter: framed, scrambled, B3ZS coded symbols.
`timescale 1ns/1ps
`default_nettype none
module srt_line_model (
    input wire logic run,
    input wire logic badB1,
    output logic lineClk,
    output logic linePos,
    output logic lineNeg,
    output logic frameMark
);
    localparam logic [15:0] SYNC = 16'hF628;
    logic frm [0:6479];
    logic [7:0] bip;
    logic [7:0] prevBip = 8'h00;
    logic [6:0] scr;
    int pol = -1;
    int odd = 0;
    int i;
    // Drives one symbol; rails settle before the clock rises.
    task automatic sym(input int p);
        linePos = (p > 0);
        lineNeg = (p < 0);
        #80 lineClk = 1'b1;
        #80 lineClk = 1'b0;
    endtask
    // Builds one frame; B1 holds the previous frame's parity.
    task automatic build;
        bip = 8'h00;
        scr = 7'h7F;
        for (i = 0; i < 6480; i++) begin
            if (i < 16) begin
                frm[i] = SYNC[15 - i];
            end else if (i < 24) begin
                frm[i] = 1'b0;
            end else begin
                frm[i] = (i < 720 || i > 727) ? i[3] :
                    prevBip[727 - i] ^ (badB1 && i == 720);
                frm[i] = frm[i] ^ scr[6];
                scr = {scr[5:0], scr[6] ^ scr[5]};
            end
            bip[7 - i % 8] = bip[7 - i % 8] ^ frm[i];
        end
        prevBip = bip;
        frameMark = !frameMark;
    endtask
    // Sends frames while running; the recovered clock runs free.
    initial begin
        lineClk = 1'b0;
        linePos = 1'b0;
        lineNeg = 1'b0;
        frameMark = 1'b0;
        #7;
        forever begin
            if (!run) begin
                sym(0);
            end else begin
                build;
                i = 0;
                while (i < 6480) begin
                    if (i < 6478 && !(frm[i] | frm[i+1] | frm[i+2])) begin
                        if (odd == 0) begin
                            pol = -pol;
                            sym(pol);
                        end else begin
                            sym(0);
                        end
                        sym(0);
                        sym(pol);
                        odd = 0;
                        i += 3;
                    end else begin
                        if (frm[i]) begin
                            pol = -pol;
                            odd ^= 1;
                        end
                        sym(frm[i] ? pol : 0);
                        i++;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* test_sub_stm1_section_receiver.sv */
// Self-checking bench for the section receiver.
`timescale 1ns/1ps
`default_nettype none
module test_sub_stm1_section_receiver;
    localparam int SEC = 60000;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic txBit = 1'b0;
    logic txBitValid = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic run = 1'b0;
    logic badB1 = 1'b0;
    wire lineClk, linePos, lineNeg, frameMark, txPos, txNeg;
    wire [31:0] regRdata;
    wire rxData, rxBitStrobe, rxFrameStart, frameLossReport;
    wire traceMismatchReport, signalLossReport, secondStrobe;
    wire nearDefectSecond;
    wire [15:0] nearErroredBlockCount;
    int mismatches = 0;
    int n_tests = 0;
    int t;
    int acc;
    logic [1:0] rec [0:15];
    logic [1:0] o;
    logic mk;
    logic [18:0] pat = 19'h78007;
    srt_receiver #(.ONE_SEC_CYCLES(SEC), .EBC_WIDTH(16)) dut (
        .clk_sys, .reset, .ce, .lineClk, .linePos, .lineNeg, .txBit,
        .txBitValid, .txPos, .txNeg, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .rxData, .rxBitStrobe, .rxFrameStart, .frameLossReport,
        .traceMismatchReport, .signalLossReport, .secondStrobe,
        .nearErroredBlockCount, .nearDefectSecond);
    srt_line_model far (.run, .badB1, .lineClk, .linePos, .lineNeg,
        .frameMark);
    // System clock.
    always #10 clk_sys = !clk_sys;
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] mask);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 check(regRdata & mask, exp, "register read");
        @(posedge clk_sys);
    endtask
    task automatic txSend(input logic b);
        txBit <= b;
        txBitValid <= 1'b1;
        @(posedge clk_sys);
        txBitValid <= 1'b0;
        #1 o = {txPos, txNeg};
        @(posedge clk_sys);
    endtask
    task automatic nextSecond;
        @(posedge clk_sys);
        for (t = 0; t < SEC + 9 && secondStrobe !== 1'b1; t++)
            @(posedge clk_sys);
        check(secondStrobe, 1'b1, "second strobe missing");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Cuts a hung run short.
    initial begin
        #15000000;
        mismatches++;
        conclude;
    end
    // Test sequence.
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rchk(8'h00, 32'h0, 32'hFFFFFFFF);
        check(signalLossReport, 1'b0, "report while unmonitored");
        rchk(8'h04, 32'h8, 32'h8);
        wr(8'h40, 32'hA5);
        rchk(8'h40, 32'hA5, 32'hFF);
        rchk(8'h80, 32'h0, 32'hFFFFFFFF);
        wr(8'h00, 32'h3);
        rchk(8'h00, 32'h3, 32'h3);
        check(signalLossReport, 1'b1, "signal loss unreported");
        check(rxData, 1'b1, "data not all ones");
        $display("done: registers");
        for (t = 18; t >= 0; t--) begin
            txSend(pat[t]);
            if (t < 16)
                rec[15 - t] = o;
        end
        acc = 0;
        for (t = 1; t < 16; t++) begin
            if (t < 4)
                check(rec[t] ^ rec[t - 1], 2'h3, "marks alternate");
            else
                acc += (rec[t] != 2'h0);
        end
        check(acc >= 4 && acc <= 8, 1'b1, "zero substitution");
        $display("done: encoder");
        check(frameLossReport, 1'b1, "frame loss hidden");
        run <= 1'b1;
        nextSecond;
        check(nearDefectSecond, 1'b1, "defect second");
        for (t = 0; t < 200000 && rxFrameStart !== 1'b1; t++)
            @(posedge clk_sys);
        check(rxFrameStart, 1'b1, "no frame alignment");
        repeat (4) @(posedge clk_sys);
        check(frameLossReport, 1'b0, "frame loss stays");
        check(signalLossReport, 1'b0, "signal loss stays");
        $display("done: alignment");
        nextSecond;
        check(nearDefectSecond, 1'b0, "clean second");
        check(nearErroredBlockCount, 16'h0, "clean count");
        badB1 <= 1'b1;
        @(posedge clk_sys);
        mk = frameMark;
        for (t = 0; t < 60000 && frameMark === mk; t++)
            @(posedge clk_sys);
        badB1 <= 1'b0;
        acc = 0;
        repeat (2) begin
            nextSecond;
            acc += nearErroredBlockCount;
        end
        check(acc, 1, "errored block count");
        $display("done: performance");
        run <= 1'b0;
        for (t = 0; t < 90000 && signalLossReport !== 1'b1; t++)
            @(posedge clk_sys);
        check(signalLossReport, 1'b1, "signal loss missed");
        check(rxData, 1'b1, "data not all ones");
        $display("done: signal loss");
        conclude;
    end
endmodule
bind srt_receiver srt_receiver_monitor portCheck (.clk_sys, .reset, .txBitValid,
    .txPos, .txNeg, .regRd, .regRdata, .rxData, .rxBitStrobe, .rxFrameStart,
    .frameLossReport, .traceMismatchReport, .signalLossReport, .secondStrobe);
`default_nettype wire
